// [fp_negated_multiply_add_unit.sv]
/*
 * Negated multiply-add / multiply-subtract slice with the paired lower-lower
 * merge, its own register file, control/status register and interrupt.
 * Assumes one clock, an Avalon-MM master with waitrequest, and a pipeline
 * that drives cop_usable on the same clock.
 */
// Decided for this implementation: the register offsets and the Avalon-MM register port.
// Notes on behaviour
// (RULE1) The product of the two multiplicands is rounded in the current rounding mode.
// (RULE2) The multiply-add adds the addend to the rounded product and rounds the exact sum.
// (RULE3) The final negation only inverts the sign bit before the destination is written.
// (RULE4) Results and flags equal those of separate multiply, add or subtract and negate steps.
// (RULE5) The multiply-subtract takes the addend from the rounded product, rounds, negates and writes.
// (RULE6) Paired-single work runs on both halves independently and ORs their conditions.
// (RULE7) With no exception taken, the new cause bits are ORed into the sticky flags.
// (RULE8) A specifier that is wrong for the format may give any result.
// (RULE9) Operands not encoded in the format may leave result and sources undefined.
// (RULE10) Paired-single results need not be defined in the reduced 16-register mode.
// (RULE11) Only coprocessor-unusable and reserved-instruction general exceptions are raised.
// (RULE12) Inexact, unimplemented, invalid, overflow and underflow are detected and reported; underflow is never raised here, tiny results raise unimplemented.
// (RULE13) Both operations exist in single, double and paired-single with four specifiers.
// (RULE14) The merge joins the first source's lower single above the second source's lower single.
// (RULE15) The merge never raises an arithmetic condition nor touches cause or flags.
// (RULE16) An enabled condition signals a floating-point exception and suppresses the write.
`timescale 1ns/1ps
`default_nettype none
module fp_negated_multiply_add_unit
    import fp_nma_pkg::*;
#(
    parameter int NUM_FPR = 32
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic cop_usable,
    output logic fp_exception,
    output logic coproc_unusable_exc,
    output logic reserved_inst_exc,
    output logic irq
);

    // Splits a packed value into sign, unbiased exponent, significand and class.
    function automatic ufp_t unpack(input logic [63:0] v, input logic dbl);
        ufp_t u;
        logic [10:0] e;
        logic [51:0] m;
        logic top;
        e = dbl ? v[62:52] : {3'h0, v[30:23]};
        m = dbl ? v[51:0] : {v[22:0], 29'h0};
        top = (e == (dbl ? 11'h7ff : 11'h0ff));
        u.sign = dbl ? v[63] : v[31];
        u.exp = $signed({3'h0, e}) - (dbl ? BIAS_D : BIAS_S);
        u.sig = {1'b1, m};
        u.zero = (e == 11'h000) && (m == 52'h0);
        u.den = (e == 11'h000) && (m != 52'h0);
        u.inf = top && (m == 52'h0);
        u.nan = top && (m != 52'h0);
        return u;
    endfunction

    // Rounds a significand normalised at bit 127 into the format; returns {cause, bits}.
    function automatic logic [68:0] round_pack(input logic sign, input logic signed [13:0] exp,
                                               input logic [127:0] sig, input logic dbl, input logic [1:0] rm);
        logic [52:0] keep;
        logic g;
        logic st;
        logic inc;
        logic [53:0] r;
        logic signed [13:0] be;
        logic [4:0] f;
        logic [63:0] out;
        logic to_inf;
        keep = dbl ? sig[127:75] : {29'h0, sig[127:104]};
        g = dbl ? sig[74] : sig[103];
        st = dbl ? |sig[73:0] : |sig[102:0];
        case (rm)
            RM_NEAREST: inc = g & (st | keep[0]);
            RM_UP: inc = ~sign & (g | st);
            RM_DOWN: inc = sign & (g | st);
            default: inc = 1'b0;
        endcase
        r = {1'b0, keep} + {53'h0, inc};
        be = exp + (dbl ? BIAS_D : BIAS_S);
        if (dbl ? r[53] : r[24]) begin
            be = be + 14'sd1;
            r = r >> 1;
        end
        f = 5'h00;
        f[C_INEXACT] = g | st;
        to_inf = (rm == RM_NEAREST) || ((rm == RM_UP) && !sign) || ((rm == RM_DOWN) && sign);
        if (be >= (dbl ? EMAX_D : EMAX_S)) begin
            f[C_OVERFLOW] = 1'b1;
            f[C_INEXACT] = 1'b1;
            if (dbl) begin
                out = to_inf ? {sign, 11'h7ff, 52'h0} : {sign, 11'h7fe, {52{1'b1}}};
            end else begin
                out = to_inf ? {32'h0, sign, 8'hff, 23'h0} : {32'h0, sign, 8'hfe, {23{1'b1}}};
            end
        end else if (be < 14'sd1) begin
            // Tiny results are handed to software rather than denormalised here.
            f[C_UNIMPL] = 1'b1;
            out = 64'h0;
        end else begin
            out = dbl ? {sign, be[10:0], r[51:0]} : {32'h0, sign, be[7:0], r[22:0]};
        end
        return {f, out};
    endfunction

    // One lane: -(a*b + c) or -(a*b - c), with the multiply trapping on its own conditions.
    function automatic logic [68:0] lane_op(input logic [63:0] a, input logic [63:0] b, input logic [63:0] c,
                                            input logic sub, input logic dbl, input logic [1:0] rm,
                                            input logic [3:0] en);
        ufp_t ua;
        ufp_t ub;
        ufp_t uc;
        ufp_t up;
        ufp_t ux;
        ufp_t uy;
        logic [105:0] prod;
        logic [68:0] rr;
        logic [63:0] pbits;
        logic [63:0] cbits;
        logic [63:0] res;
        logic [63:0] qnan;
        logic [4:0] f;
        logic done;
        logic sy;
        logic sr;
        logic [13:0] d;
        logic [127:0] bx;
        logic [127:0] by;
        logic [127:0] sm;
        logic [6:0] lz;
        logic found;
        qnan = dbl ? QNAN_D : {32'h0, QNAN_S};
        ua = unpack(a, dbl);
        ub = unpack(b, dbl);
        uc = unpack(c, dbl);
        f = 5'h00;
        done = 1'b0;
        res = qnan;
        pbits = 64'h0;
        prod = 106'h0;
        lz = 7'h00;
        found = 1'b0;
        sy = uc.sign ^ sub;                                            // RULE5
        cbits = dbl ? {sy, c[62:0]} : {32'h0, sy, c[30:0]};
        if (ua.den | ub.den | uc.den) begin
            f[C_UNIMPL] = 1'b1;                                        // RULE12
            done = 1'b1;
        end else if (ua.nan | ub.nan | uc.nan) begin
            // A NaN reaches the negate step, which treats it as invalid.
            f[C_INVALID] = 1'b1;                                       // RULE4
            done = 1'b1;
        end else if ((ua.inf & ub.zero) | (ua.zero & ub.inf)) begin
            f[C_INVALID] = 1'b1;
            done = 1'b1;
        end else if (ua.inf | ub.inf) begin
            pbits = dbl ? {ua.sign ^ ub.sign, 11'h7ff, 52'h0} : {32'h0, ua.sign ^ ub.sign, 8'hff, 23'h0};
        end else if (ua.zero | ub.zero) begin
            pbits = dbl ? {ua.sign ^ ub.sign, 63'h0} : {32'h0, ua.sign ^ ub.sign, 31'h0};
        end else begin
            prod = ua.sig * ub.sig;
            rr = round_pack(ua.sign ^ ub.sign, ua.exp + ub.exp + (prod[105] ? 14'sd1 : 14'sd0),
                            prod[105] ? {prod, 22'h0} : {prod[104:0], 23'h0}, dbl, rm);  // RULE1
            f = rr[68:64];
            pbits = rr[63:0];
            // A trapping multiply ends the sequence before the add is attempted.
            done = f[C_UNIMPL] | (|(f[3:0] & en));                     // RULE4
        end
        if (!done) begin
            up = unpack(pbits, dbl);
            if (up.inf & uc.inf & (up.sign != sy)) begin
                f[C_INVALID] = 1'b1;
            end else if (up.inf | (uc.zero & !up.zero)) begin
                res = pbits;
            end else if (uc.inf | up.zero & !uc.zero) begin
                res = cbits;
            end else if (up.zero) begin
                sr = (up.sign & sy) | ((up.sign | sy) & (rm == RM_DOWN));
                res = dbl ? {sr, 63'h0} : {32'h0, sr, 31'h0};
            end else begin
                // Larger magnitude first so that a difference never goes negative.
                if ((up.exp > uc.exp) || ((up.exp == uc.exp) && (up.sig >= uc.sig))) begin
                    ux = up;
                    uy = uc;
                    uy.sign = sy;
                end else begin
                    ux = uc;
                    ux.sign = sy;
                    uy = up;
                end
                d = 14'(ux.exp - uy.exp);
                bx = {1'b0, ux.sig, 74'h0};
                by = {1'b0, uy.sig, 74'h0};
                if (d > 14'd126) begin
                    by = 128'h1;
                end else begin
                    by = (by >> d) | {127'h0, |(by & ((128'h1 << d) - 128'h1))};
                end
                sm = (ux.sign == uy.sign) ? bx + by : bx - by;           // RULE2
                if (sm == 128'h0) begin
                    res = dbl ? {rm == RM_DOWN, 63'h0} : {32'h0, rm == RM_DOWN, 31'h0};
                end else begin
                    for (int i = 127; i >= 0; i--) begin
                        if (!found && sm[i]) begin
                            lz = 7'(127 - i);
                            found = 1'b1;
                        end
                    end
                    rr = round_pack(ux.sign, ux.exp + 14'sd1 - $signed({7'h0, lz}), sm << lz, dbl, rm);
                    f = f | rr[68:64];
                    res = rr[63:0];
                end
            end
        end
        res = dbl ? {~res[63], res[62:0]} : {32'h0, ~res[31], res[30:0]};  // RULE3
        return {f, res};
    endfunction

    // Register state.
    logic [63:0] fp_register_file [NUM_FPR];
    logic [31:0] fp_control_status_reg;
    logic [4:0] fpr_index;
    logic [2:0] last_event;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic ack;
    logic [31:0] read_mux;

    // Bus handshake: every access waits exactly one cycle.
    wire logic req = read | write;
    wire logic wr_take = write & ack;
    assign waitrequest = req & ~ack;

    // Command field decode, taken straight from the write data.
    wire logic cmd_issue = wr_take && (address == OFS_CMD);
    wire op_t cmd_op = op_t'(writedata[CMD_OP_LSB +: 2]);
    wire fmt_t cmd_fmt = fmt_t'(writedata[CMD_FMT_LSB +: 2]);
    wire logic [4:0] fd_idx = writedata[CMD_FD_LSB +: 5];
    wire logic [4:0] fr_idx = writedata[CMD_FR_LSB +: 5];
    wire logic [4:0] fs_idx = writedata[CMD_FS_LSB +: 5];
    wire logic [4:0] ft_idx = writedata[CMD_FT_LSB +: 5];
    // Specifiers simply index the file; odd or out-of-range ones get no check.
    wire logic [63:0] fr_val = fp_register_file[fr_idx];                             // RULE8
    wire logic [63:0] fs_val = fp_register_file[fs_idx];
    wire logic [63:0] ft_val = fp_register_file[ft_idx];
    wire logic [63:0] fd_old = fp_register_file[fd_idx];

    // Format/opcode legality and general exceptions; unusable has priority.
    wire logic is_dbl = (cmd_fmt == fmt_double);
    wire logic is_ps = (cmd_fmt == paired_single_format);
    wire logic is_pll = (cmd_op == pair_lower_lower_merge_op);
    wire logic bad_op = (cmd_op == op_t'(2'h2)) || (cmd_fmt == fmt_t'(2'h2)) || (is_pll && !is_ps);  // RULE13
    wire logic gen_unusable = cmd_issue & ~cop_usable;                  // RULE11
    wire logic gen_reserved = cmd_issue & cop_usable & bad_op;          // RULE11
    wire logic do_arith = cmd_issue & cop_usable & ~bad_op & ~is_pll;  // RULE15
    wire logic do_pll = cmd_issue & cop_usable & ~bad_op & is_pll;

    // Two lanes: lane 0 serves single, double and the lower pair half; lane 1 the upper half.
    logic [68:0] lane_out [2];
    genvar ln;
    generate
        for (ln = 0; ln < 2; ln++) begin : g_lane
            wire logic [63:0] la = (ln == 0) ? fs_val : {32'h0, fs_val[63:32]};
            wire logic [63:0] lb = (ln == 0) ? ft_val : {32'h0, ft_val[63:32]};
            wire logic [63:0] lc = (ln == 0) ? fr_val : {32'h0, fr_val[63:32]};
            // Paired halves use identical logic; the reduced register mode is not checked.
            assign lane_out[ln] = lane_op(la, lb, lc, cmd_op == negated_multiply_subtract_op,
                                          (ln == 0) && is_dbl, fp_control_status_reg[FP_CONTROL_STATUS_REG_RM_LSB +: 2],
                                          fp_control_status_reg[FP_CONTROL_STATUS_REG_EN_LSB +: 4]);  // RULE6 RULE10
        end
    endgenerate

    // Combine lanes, then decide on the trap.
    wire logic [4:0] cause_new = lane_out[0][68:64] | (is_ps ? lane_out[1][68:64] : 5'h00);  // RULE6
    wire logic [63:0] arith_res = is_dbl ? lane_out[0][63:0] :
                                  is_ps ? {lane_out[1][31:0], lane_out[0][31:0]} : {32'h0, lane_out[0][31:0]};
    wire logic fp_trap = do_arith & (cause_new[C_UNIMPL] |
                                     (|(cause_new[3:0] & fp_control_status_reg[FP_CONTROL_STATUS_REG_EN_LSB +: 4])));  // RULE16
    wire logic [63:0] pll_res = {fs_val[31:0], ft_val[31:0]};           // RULE14
    wire logic wr_dst = (do_arith & ~fp_trap) | do_pll;                 // RULE16
    wire logic [63:0] dst_val = do_pll ? pll_res : arith_res;
    wire logic [IRQ_W-1:0] irq_event = {gen_reserved, gen_unusable, fp_trap};
    wire logic [IRQ_W-1:0] irq_clear = (wr_take && (address == OFS_IRQ_CLEAR)) ? writedata[IRQ_W-1:0] : '0;

    // Read selection.
    assign read_mux = (address == OFS_FP_CONTROL_STATUS_REG) ? fp_control_status_reg :
                      (address == OFS_STATUS) ? {29'h0, last_event} :
                      (address == OFS_FPR_INDEX) ? {27'h0, fpr_index} :
                      (address == OFS_FPR_LO) ? fp_register_file[fpr_index][31:0] :
                      (address == OFS_FPR_HI) ? fp_register_file[fpr_index][63:32] :
                      (address == OFS_IRQ_STATUS) ? {29'h0, irq_status} :
                      (address == OFS_IRQ_ENABLE) ? {29'h0, irq_enable} : 32'h0;
    assign irq = |(irq_status & irq_enable);

    // Bus acknowledge and read data, captured in the waiting cycle.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack <= 1'b0;
            readdata <= 32'h0;
        end else begin
            ack <= req & ~ack;
            if (read & ~ack) begin
                readdata <= read_mux;
            end
        end
    end

    // Register file: bus windows and instruction results never share a cycle.
    always_ff @(posedge mclk) begin
        if (wr_take && (address == OFS_FPR_LO)) begin
            fp_register_file[fpr_index][31:0] <= writedata;
        end else if (wr_take && (address == OFS_FPR_HI)) begin
            fp_register_file[fpr_index][63:32] <= writedata;
        end else if (wr_dst) begin
            fp_register_file[fd_idx] <= dst_val;                                     // RULE3 RULE9
        end
    end

    // Control/status: cause always reloads on arithmetic, flags only when no trap.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fp_control_status_reg <= FP_CONTROL_STATUS_REG_RESET;
        end else if (wr_take && (address == OFS_FP_CONTROL_STATUS_REG)) begin
            fp_control_status_reg <= {17'h0, writedata[14:0]};
        end else if (do_arith) begin
            fp_control_status_reg[FP_CONTROL_STATUS_REG_CAUSE_LSB +: 5] <= cause_new;    // RULE12
            if (!fp_trap) begin
                fp_control_status_reg[FP_CONTROL_STATUS_REG_FLAG_LSB +: 4] <= fp_control_status_reg[FP_CONTROL_STATUS_REG_FLAG_LSB +: 4]
                                                             | cause_new[3:0];  // RULE7
            end
        end
    end

    // Index, interrupt state and exception pulses; a new event beats a clear.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fpr_index <= 5'h00;
            irq_enable <= '0;
            irq_status <= '0;
            last_event <= 3'h0;
            fp_exception <= 1'b0;
            coproc_unusable_exc <= 1'b0;
            reserved_inst_exc <= 1'b0;
        end else begin
            if (wr_take && (address == OFS_FPR_INDEX)) begin
                fpr_index <= writedata[4:0];
            end
            if (wr_take && (address == OFS_IRQ_ENABLE)) begin
                irq_enable <= writedata[IRQ_W-1:0];
            end
            irq_status <= (irq_status & ~irq_clear) | irq_event;
            if (cmd_issue) begin
                last_event <= irq_event;
            end
            fp_exception <= fp_trap;                                    // RULE16
            coproc_unusable_exc <= gen_unusable;                        // RULE11
            reserved_inst_exc <= gen_reserved;
        end
    end

    // Helpers that hold the previous cycle's destination field and its old value for the checks below.
    logic [4:0] chk_fd;
    logic [63:0] chk_old;
    always_ff @(posedge mclk) begin
        chk_fd <= fd_idx;
        chk_old <= fd_old;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_bus_one_wait: assert property (req && waitrequest |=> !waitrequest)
        else $error("bus access waited more than one cycle");
    a_trap_no_write: assert property (fp_trap |=> fp_register_file[chk_fd] == chk_old) // RULE16
        else $error("destination written despite a trap");
    a_trap_pulse: assert property (fp_trap |=> fp_exception ##1 !fp_exception) // RULE16
        else $error("floating-point exception pulse wrong");
    a_flags_sticky_or: assert property (do_arith && !fp_trap |=> // RULE7
        fp_control_status_reg[5:2] == ($past(fp_control_status_reg[5:2]) | $past(cause_new[3:0])))
        else $error("flags not accumulated");
    a_trap_flags_hold: assert property (fp_trap |=> $stable(fp_control_status_reg[5:2])) // RULE7
        else $error("flags changed on a trap");
    a_merge_quiet: assert property (do_pll |=> $stable(fp_control_status_reg)) // RULE15
        else $error("merge touched the control/status register");
    a_merge_data: assert property (do_pll ##1 1'b1 |-> fp_register_file[chk_fd] == $past(pll_res)) // RULE14
        else $error("merge result wrong");
    a_unusable_only: assert property (cmd_issue && !cop_usable |=> coproc_unusable_exc && !fp_exception) // RULE11
        else $error("unusable coprocessor not reported alone");
    a_unimpl_traps: assert property (do_arith && cause_new[4] |-> fp_trap ##1 fp_exception) // RULE12
        else $error("unimplemented operation did not trap");

    c_add_clean: cover property (do_arith && cmd_op == negated_multiply_add_op && !fp_trap);
    c_sub_trap: cover property (do_arith && cmd_op == negated_multiply_subtract_op && fp_trap);
    c_ps_arith: cover property (do_arith && is_ps);
    c_merge: cover property (do_pll);

endmodule
`default_nettype wire

// [fp_nma_pkg.sv]
/*
 * Shared constants and types for the negated multiply-add slice: the register
 * map, the field layouts, the rounding and cause encodings and the unpacked
 * operand type.
 * Assumes a 32-bit Avalon-MM slave with byte addresses on word boundaries.
 */
`default_nettype none
package fp_nma_pkg;
    // Byte offsets of the slave registers.
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_FP_CONTROL_STATUS_REG = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FPR_INDEX = 8'h0c;
    localparam logic [7:0] OFS_FPR_LO = 8'h10;
    localparam logic [7:0] OFS_FPR_HI = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1c;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;
    // Command word fields, lowest bit of each.
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_FMT_LSB = 2;
    localparam int CMD_FD_LSB = 4;
    localparam int CMD_FR_LSB = 9;
    localparam int CMD_FS_LSB = 14;
    localparam int CMD_FT_LSB = 19;
    // Control/status register fields and reset value.
    localparam int FP_CONTROL_STATUS_REG_RM_LSB = 0;
    localparam int FP_CONTROL_STATUS_REG_FLAG_LSB = 2;
    localparam int FP_CONTROL_STATUS_REG_EN_LSB = 6;
    localparam int FP_CONTROL_STATUS_REG_CAUSE_LSB = 10;
    localparam logic [31:0] FP_CONTROL_STATUS_REG_RESET = 32'h0000_0000;
    // Cause vector bit positions; the low four also index flags and enables.
    localparam int C_INEXACT = 0;
    localparam int C_UNDERFLOW = 1;
    localparam int C_OVERFLOW = 2;
    localparam int C_INVALID = 3;
    localparam int C_UNIMPL = 4;
    // Rounding modes.
    localparam logic [1:0] RM_NEAREST = 2'h0;
    localparam logic [1:0] RM_ZERO = 2'h1;
    localparam logic [1:0] RM_UP = 2'h2;
    localparam logic [1:0] RM_DOWN = 2'h3;
    // Interrupt status bits.
    localparam int IRQ_FP = 0;
    localparam int IRQ_UNUSABLE = 1;
    localparam int IRQ_RESERVED = 2;
    localparam int IRQ_W = 3;
    // Format constants.
    localparam logic signed [13:0] BIAS_S = 14'sd127;
    localparam logic signed [13:0] BIAS_D = 14'sd1023;
    localparam logic signed [13:0] EMAX_S = 14'sd255;
    localparam logic signed [13:0] EMAX_D = 14'sd2047;
    localparam logic [31:0] QNAN_S = 32'h7fc0_0000;
    localparam logic [63:0] QNAN_D = 64'h7ff8_0000_0000_0000;

    typedef enum logic [1:0] {
        negated_multiply_add_op = 2'h0,
        negated_multiply_subtract_op = 2'h1,
        pair_lower_lower_merge_op = 2'h3
    } op_t;

    typedef enum logic [1:0] {
        fmt_single = 2'h0,
        fmt_double = 2'h1,
        paired_single_format = 2'h3
    } fmt_t;

    typedef struct packed {
        logic sign;
        logic signed [13:0] exp;
        logic [52:0] sig;
        logic zero;
        logic inf;
        logic nan;
        logic den;
    } ufp_t;
endpackage
`default_nettype wire

// [cop_pipe_model.sv]
/* Pipeline-side model that grants or withdraws the coprocessor.
   Assumes the bench requests a change one cycle ahead of the command. */
`timescale 1ns/1ps
`default_nettype none
module cop_pipe_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic usable_req,
    output logic cop_usable
);
    // The grant lags the request by one edge, as a status update in a real pipeline would.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cop_usable <= 1'b1;
        end else begin
            cop_usable <= usable_req;
        end
    end
endmodule
`default_nettype wire

// [test_fp_negated_multiply_add_unit.sv]
/* Self-checking bench for the negated multiply-add slice.
   Assumes the design package and the pipeline model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_fp_negated_multiply_add_unit;
    import fp_nma_pkg::*;
    logic mclk = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0, usable_req = 1'b1;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic waitrequest, cop_usable, fp_exception, coproc_unusable_exc, reserved_inst_exc, irq;
    int n_errors = 0, checks_done = 0;
    fp_negated_multiply_add_unit i_fp_negated_multiply_add_unit (.mclk(mclk), .reset_n(reset_n),
        .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .cop_usable(cop_usable), .fp_exception(fp_exception),
        .coproc_unusable_exc(coproc_unusable_exc), .reserved_inst_exc(reserved_inst_exc), .irq(irq));
    cop_pipe_model i_cop_pipe_model (.mclk(mclk), .reset_n(reset_n), .usable_req(usable_req),
        .cop_usable(cop_usable));
    // Clock of 8 ns.
    initial begin
        forever #4 mclk = ~mclk;
    end
    task tally_and_finish;
        if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One bus access: raised after an edge, held until waitrequest is seen low at a rising edge.
    // Returns half a cycle later, so that outputs launched at that edge are settled for checks.
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        @(posedge mclk);
        while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (waitrequest !== 1'b0) begin
            n_errors++;
            tally_and_finish;
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(negedge mclk);
    endtask
    task ld(input logic [4:0] i, input logic [63:0] v);
        bus(1'b1, OFS_FPR_INDEX, {27'h0, i});
        bus(1'b1, OFS_FPR_LO, v[31:0]);
        bus(1'b1, OFS_FPR_HI, v[63:32]);
    endtask
    task rdf(input logic [4:0] i, input logic [63:0] v);
        bus(1'b1, OFS_FPR_INDEX, {27'h0, i});
        bus(1'b0, OFS_FPR_LO, 32'h0);
        check(q, v[31:0]);
        bus(1'b0, OFS_FPR_HI, 32'h0);
        check(q, v[63:32]);
    endtask
    // Issues a command and checks the three exception pulses in the cycle after it is taken.
    task cmd(input logic [1:0] op, input logic [1:0] fmt, input logic [4:0] fd, input logic [4:0] fr,
             input logic [4:0] fs, input logic [4:0] ft, input logic [2:0] exc);
        bus(1'b1, OFS_CMD, {8'h00, ft, fs, fr, fd, fmt, op});
        check({29'h0, reserved_inst_exc, coproc_unusable_exc, fp_exception}, {29'h0, exc});
    endtask
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        bus(1'b0, OFS_FP_CONTROL_STATUS_REG, 32'h0);
        check(q, FP_CONTROL_STATUS_REG_RESET);
        ld(5'd1, {2{32'h4000_0000}});
        ld(5'd2, {2{32'h4040_0000}});
        ld(5'd3, {2{32'h3f80_0000}});
        ld(5'd8, {32'h0, 32'h3f80_0001});
        ld(5'd9, 64'h0);
        ld(5'd10, {2{32'h1234_5678}});
        ld(5'd11, 64'h4000_0000_0000_0000);
        ld(5'd12, 64'h4008_0000_0000_0000);
        ld(5'd13, 64'h3ff0_0000_0000_0000);
        cmd(negated_multiply_add_op, fmt_single, 5'd4, 5'd3, 5'd1, 5'd2, 3'h0);
        rdf(5'd4, {32'h0, 32'hc0e0_0000});
        cmd(negated_multiply_subtract_op, fmt_single, 5'd5, 5'd3, 5'd1, 5'd2, 3'h0);
        rdf(5'd5, {32'h0, 32'hc0a0_0000});
        cmd(negated_multiply_add_op, fmt_double, 5'd6, 5'd13, 5'd11, 5'd12, 3'h0);
        rdf(5'd6, 64'hc01c_0000_0000_0000);
        cmd(negated_multiply_add_op, paired_single_format, 5'd7, 5'd3, 5'd1, 5'd2, 3'h0);
        rdf(5'd7, {2{32'hc0e0_0000}});
        cmd(pair_lower_lower_merge_op, paired_single_format, 5'd14, 5'd0, 5'd4, 5'd5, 3'h0);
        rdf(5'd14, {32'hc0e0_0000, 32'hc0a0_0000});
        cmd(negated_multiply_add_op, fmt_single, 5'd15, 5'd9, 5'd8, 5'd8, 3'h0);
        rdf(5'd15, {32'h0, 32'hbf80_0002});
        bus(1'b0, OFS_FP_CONTROL_STATUS_REG, 32'h0);
        check(q, 32'h0000_0404);
        cmd(pair_lower_lower_merge_op, paired_single_format, 5'd14, 5'd0, 5'd5, 5'd4, 3'h0);
        bus(1'b0, OFS_FP_CONTROL_STATUS_REG, 32'h0);
        check(q, 32'h0000_0404);
        bus(1'b1, OFS_FP_CONTROL_STATUS_REG, 32'h0000_0040);
        cmd(negated_multiply_add_op, fmt_single, 5'd10, 5'd9, 5'd8, 5'd8, 3'h1);
        rdf(5'd10, {2{32'h1234_5678}});
        bus(1'b0, OFS_FP_CONTROL_STATUS_REG, 32'h0);
        check(q, 32'h0000_0440);
        cmd(negated_multiply_add_op, fmt_double, 5'd10, 5'd13, 5'd8, 5'd11, 3'h1);
        bus(1'b0, OFS_FP_CONTROL_STATUS_REG, 32'h0);
        check(q, 32'h0000_4040);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, OFS_IRQ_ENABLE, 32'h7);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, OFS_IRQ_CLEAR, 32'h1);
        check({31'h0, irq}, 32'h0);
        @(posedge mclk);
        usable_req <= 1'b0;
        @(posedge mclk);
        cmd(negated_multiply_add_op, fmt_single, 5'd16, 5'd3, 5'd1, 5'd2, 3'h2);
        @(posedge mclk);
        usable_req <= 1'b1;
        @(posedge mclk);
        cmd(2'h2, fmt_single, 5'd16, 5'd3, 5'd1, 5'd2, 3'h4);
        cmd(pair_lower_lower_merge_op, fmt_single, 5'd16, 5'd0, 5'd1, 5'd2, 3'h4);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        check(q, 32'h6);
        bus(1'b0, OFS_STATUS, 32'h0);
        check(q, 32'h4);
        check({31'h0, irq}, 32'h1);
        bus(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
